//--- css_pkg.sv
`default_nettype none
package css_pkg;
  localparam int CSS_DW = 16;
  localparam int CSS_AW = 8;

  // Register byte offsets on the plain register port.
  localparam logic [CSS_AW-1:0] CSS_PLLC_OFF = 8'h00;
  localparam logic [CSS_AW-1:0] CSS_POWERC_OFF = 8'h04;
  localparam logic [CSS_AW-1:0] CSS_STATUS_OFF = 8'h08;
  localparam logic [CSS_AW-1:0] CSS_IRQ_STAT_OFF = 8'h0c;
  localparam logic [CSS_AW-1:0] CSS_IRQ_MASK_OFF = 8'h10;

  // Reset values.
  localparam logic [CSS_DW-1:0] CSS_PLLC_RESET = 16'h0000;
  localparam logic [CSS_DW-1:0] CSS_POWERC_RESET = 16'h0000;
  localparam logic [1:0] CSS_IRQ_RESET = 2'h0;

  // Field positions.
  localparam int CSS_PLL_EN_BIT = 15;
  localparam int CSS_PLL_SEL_BIT = 14;
  localparam int CSS_SLOW_BIT = 10;
  localparam int CSS_MBITS_LO = 0;
  localparam int CSS_NBITS_LO = 5;
  localparam int CSS_IRQ_LOCK_BIT = 0;
  localparam int CSS_IRQ_SWITCH_BIT = 1;

  // Divider encodings: M is Mbits plus two, N is Nbits plus two, except 7 meaning one.
  localparam logic [4:0] CSS_M_BIAS = 5'h02;
  localparam logic [3:0] CSS_N_BIAS = 4'h2;
  localparam logic [2:0] CSS_NBITS_ONE = 3'h7;

  // Timing: clock period and the behavioural ring oscillator half period.
  localparam int CSS_CLK_PERIOD_PS = 4000;
  localparam int CSS_RING_HALF_PS = 200000;
  localparam logic [7:0] CSS_RING_HALF_CYCLES = 8'(CSS_RING_HALF_PS / CSS_CLK_PERIOD_PS);
  // Behavioural PLL lock time in rising edges of the external input.
  localparam logic [7:0] CSS_LOCK_EDGES = 8'h40;

  typedef struct packed {
    logic [CSS_AW-1:0] addr;
    logic [CSS_DW-1:0] wdata;
    logic write;
    logic read;
  } css_bus_req_t;

  typedef enum logic [1:0] {
    CSS_SRC_EXT,
    CSS_SRC_SLOW,
    CSS_SRC_PLL
  } css_src_t;
endpackage
`default_nettype wire

//--- css_clock_select.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module css_clock_select
  import css_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire css_bus_req_t busReq,
  output logic [CSS_DW-1:0] readData,
  input wire logic externalClockInput,
  input wire logic clockStop,
  output logic pllPowerEnable,
  output logic firstCoreLock,
  output logic secondCoreLock,
  output logic coreClock,
  output logic [1:0] activeSource,
  output logic irq
);

  logic [CSS_DW-1:0] pllControl;
  logic [CSS_DW-1:0] powerControl;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;

  // Register decode.
  wire pllcWrite = busReq.write && (busReq.addr == CSS_PLLC_OFF);
  wire powercWrite = busReq.write && (busReq.addr == CSS_POWERC_OFF);
  wire irqStatWrite = busReq.write && (busReq.addr == CSS_IRQ_STAT_OFF);
  wire irqMaskWrite = busReq.write && (busReq.addr == CSS_IRQ_MASK_OFF);

  wire pllSourceSelect = pllControl[CSS_PLL_SEL_BIT];
  wire pllEnableBit = pllControl[CSS_PLL_EN_BIT];
  wire slowClockSelect = powerControl[CSS_SLOW_BIT];
  wire [4:0] mBits = pllControl[CSS_MBITS_LO +: 5];
  wire [2:0] nBits = pllControl[CSS_NBITS_LO +: 3];

  // The external input arrives from a pin; a level counts once two stages agree.
  logic [2:0] extSync;
  logic extLevel;
  wire extStable = extSync[1] == extSync[2];
  wire extRise = extStable && extSync[2] && !extLevel;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      extSync <= 3'h0;
      extLevel <= 1'b0;
    end else begin
      extSync <= {extSync[1:0], externalClockInput};
      if (extStable) begin
        extLevel <= extSync[2];
      end
    end
  end

  // Ring oscillator model: runs free from reset, needs no outside stimulus.
  logic [7:0] ringCount;
  logic ringLevel;
  wire ringWrap = ringCount == (CSS_RING_HALF_CYCLES - 8'h01);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ringCount <= 8'h00;
      ringLevel <= 1'b0;
    end else begin
      ringCount <= ringWrap ? 8'h00 : ringCount + 8'h01;
      if (ringWrap) begin
        ringLevel <= !ringLevel;
      end
    end
  end

  // PLL model: measures the input period, then a phase accumulator adding M per
  // cycle toggles the output each time it passes N periods, giving M/2N times fin.
  // Until one input rise has been measured the limit is zero and the output stays low.
  logic [15:0] periodCount;
  logic [15:0] extPeriod;
  logic [20:0] phaseAcc;
  logic pllLevel;
  wire [4:0] mValue = mBits + CSS_M_BIAS;
  wire [3:0] nValue = (nBits == CSS_NBITS_ONE) ? 4'h1 : {1'b0, nBits} + CSS_N_BIAS;
  wire [19:0] phaseLimit = nValue * extPeriod;
  wire [20:0] phaseSum = phaseAcc + {16'h0000, mValue};
  wire phaseWrap = (phaseLimit != 20'h00000) && (phaseSum >= {1'b0, phaseLimit});

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      periodCount <= 16'h0000;
      extPeriod <= 16'h0000;
    end else if (extRise) begin
      periodCount <= 16'h0000;
      extPeriod <= periodCount + 16'h0001;
    end else if (periodCount != 16'hffff) begin
      periodCount <= periodCount + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phaseAcc <= 21'h000000;
      pllLevel <= 1'b0;
    end else if (!pllEnableBit) begin
      phaseAcc <= 21'h000000;
      pllLevel <= 1'b0;
    end else if (phaseWrap) begin
      phaseAcc <= phaseSum - {1'b0, phaseLimit};
      pllLevel <= !pllLevel;
    end else begin
      phaseAcc <= phaseSum;
    end
  end

  // Lock: counts input edges while powered with untouched settings.
  // A write to the pll control register restarts the count, so a new setting never inherits an old lock.
  logic [7:0] lockCount;
  logic lockFlag;
  wire lockDone = extRise && !lockFlag && (lockCount == CSS_LOCK_EDGES - 8'h01);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lockCount <= 8'h00;
      lockFlag <= 1'b0;
    end else if (pllcWrite || !pllEnableBit) begin
      lockCount <= 8'h00;
      lockFlag <= 1'b0;
    end else if (lockDone) begin
      lockFlag <= 1'b1;
    end else if (extRise && !lockFlag) begin
      lockCount <= lockCount + 8'h01;
    end
  end

  // Source selection: candidates are already synchronous to this clock, and the
  // switch is only taken while both the old and new source sit low.
  css_src_t curSource;
  css_src_t wantSource;
  logic stopGate;
  logic curLevel;
  logic candLevel;

  always_comb begin
    if (pllSourceSelect) begin
      wantSource = CSS_SRC_PLL;
    end else if (slowClockSelect) begin
      wantSource = CSS_SRC_SLOW;
    end else begin
      wantSource = CSS_SRC_EXT;
    end
  end

  always_comb begin
    case (curSource)
      CSS_SRC_EXT: curLevel = extLevel;
      CSS_SRC_SLOW: curLevel = ringLevel;
      CSS_SRC_PLL: curLevel = pllLevel;
      default: curLevel = 1'b0;
    endcase
  end

  always_comb begin
    case (wantSource)
      CSS_SRC_EXT: candLevel = extLevel;
      CSS_SRC_SLOW: candLevel = ringLevel;
      CSS_SRC_PLL: candLevel = pllLevel;
      default: candLevel = 1'b0;
    endcase
  end

  // Waiting for the output itself to sit low as well keeps a high phase from being cut short.
  wire switchNow = (wantSource != curSource) && !curLevel && !candLevel && !coreClock;
  wire next_coreClock = curLevel && !stopGate;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      curSource <= CSS_SRC_EXT;
      stopGate <= 1'b0;
      coreClock <= 1'b0;
    end else begin
      if (switchNow) begin
        curSource <= wantSource;
      end
      // The stop request only takes effect while the clock is low.
      if (!curLevel) begin
        stopGate <= clockStop;
      end
      coreClock <= next_coreClock;
    end
  end

  // Registers, interrupt status and read port.
  wire lockEvent = lockDone && !pllcWrite;
  wire [1:0] irqEvents = {switchNow, lockEvent};
  wire [1:0] irqClear = irqStatWrite ? busReq.wdata[1:0] : 2'h0;
  logic [CSS_DW-1:0] readMux;

  always_comb begin
    case (busReq.addr)
      CSS_PLLC_OFF: readMux = pllControl;
      CSS_POWERC_OFF: readMux = powerControl;
      CSS_STATUS_OFF: readMux = {13'h0000, curSource, lockFlag};
      CSS_IRQ_STAT_OFF: readMux = {14'h0000, irqStatus};
      CSS_IRQ_MASK_OFF: readMux = {14'h0000, irqMask};
      default: readMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pllControl <= CSS_PLLC_RESET;
      powerControl <= CSS_POWERC_RESET;
      irqStatus <= CSS_IRQ_RESET;
      irqMask <= CSS_IRQ_RESET;
      readData <= 16'h0000;
    end else begin
      if (pllcWrite) begin
        pllControl <= busReq.wdata;
      end
      if (powercWrite) begin
        powerControl <= busReq.wdata;
      end
      if (irqMaskWrite) begin
        irqMask <= busReq.wdata[1:0];
      end
      // A new event wins over a clear in the same cycle.
      irqStatus <= (irqStatus & ~irqClear) | irqEvents;
      // Read data stand for one cycle only and drop to zero otherwise.
      readData <= busReq.read ? readMux : 16'h0000;
    end
  end

  assign pllPowerEnable = pllEnableBit;
  assign firstCoreLock = lockFlag;
  assign secondCoreLock = lockFlag;
  assign activeSource = curSource;
  assign irq = |(irqStatus & irqMask);

  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic anyControlWrite;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      anyControlWrite <= 1'b0;
    end else if (pllcWrite || powercWrite) begin
      anyControlWrite <= 1'b1;
    end
  end

  sequence sourceChange;
    curSource != $past(curSource);
  endsequence

  sequence stableRunOn(css_src_t s);
    curSource == s && !stopGate && $stable(curSource);
  endsequence

  sequence stayOn(css_src_t s);
    stableRunOn(s) ##1 curSource == s;
  endsequence

  sequence lockSettled;
    $past(extRise) && $past(lockCount) == (CSS_LOCK_EDGES - 8'h01) && pllEnableBit;
  endsequence

  // The stage pair agreed one edge back, the only way the pin level may move.
  sequence syncAgreed;
    $past(extSync[1]) == $past(extSync[2]);
  endsequence

  sequence ringWrapped;
    $past(ringCount) == (CSS_RING_HALF_CYCLES - 8'h01);
  endsequence

  sequence lockUntouched;
    lockFlag && !pllcWrite;
  endsequence

  reset_default_a: assert property (!anyControlWrite |-> curSource == CSS_SRC_EXT && pllControl == CSS_PLLC_RESET)
    else $error("source or pll control left reset default without a write");
  select_table_a: assert property (sourceChange |-> curSource == $past(wantSource))
    else $error("source switched to an unrequested clock");
  glitch_free_a: assert property (sourceChange |-> !$past(coreClock) && !coreClock)
    else $error("source switched while clock output high");
  ext_follow_a: assert property (stayOn(CSS_SRC_EXT) |-> coreClock == $past(extLevel))
    else $error("clock does not follow external input");
  slow_follow_a: assert property (stayOn(CSS_SRC_SLOW) |-> coreClock == $past(ringLevel))
    else $error("clock does not follow ring oscillator");
  pll_follow_a: assert property (stayOn(CSS_SRC_PLL) |-> coreClock == $past(pllLevel))
    else $error("clock does not follow pll output");
  power_bit_a: assert property (pllPowerEnable == pllControl[CSS_PLL_EN_BIT])
    else $error("pll power does not track enable bit");
  pll_off_a: assert property (!pllPowerEnable |=> !pllLevel)
    else $error("pll output runs while powered down");
  lock_rise_a: assert property ($rose(lockFlag) |-> lockSettled)
    else $error("lock rose before the settle count");
  lock_clear_a: assert property (pllcWrite |=> !lockFlag)
    else $error("pll control write left lock set");
  core_lock_a: assert property (firstCoreLock == lockFlag && secondCoreLock == lockFlag)
    else $error("cores see different lock");
  stop_clock_a: assert property (stopGate [*2] |-> !coreClock)
    else $error("clock runs while stopped");

  // The source table, one row per case, then the switch and clock output checks.
  pick_pll_a: assert property (pllSourceSelect |-> wantSource == CSS_SRC_PLL)
    else $error("pll select did not pick the pll");
  pick_slow_a: assert property (!pllSourceSelect && slowClockSelect |-> wantSource == CSS_SRC_SLOW)
    else $error("slow select did not pick the ring");
  pick_ext_a: assert property (!pllSourceSelect && !slowClockSelect |-> wantSource == CSS_SRC_EXT)
    else $error("clear selects did not pick the external input");
  switch_wait_a: assert property (wantSource == curSource |=> $stable(curSource))
    else $error("source moved without a request");
  switch_event_a: assert property (sourceChange |-> irqStatus[CSS_IRQ_SWITCH_BIT])
    else $error("source switch did not raise its status bit");
  core_low_a: assert property (!curLevel |=> !coreClock)
    else $error("clock went high out of a low source");

  ext_sync_a: assert property ($changed(extLevel) |-> syncAgreed)
    else $error("pin level moved before two stages agreed");
  period_hold_a: assert property (extRise |=> extPeriod == $past(periodCount) + 16'h0001)
    else $error("input period not taken at the input rise");
  ring_toggle_a: assert property ($changed(ringLevel) |-> ringWrapped)
    else $error("ring toggled off its half period");
  ring_run_a: assert property (!ringWrap |=> ringCount == $past(ringCount) + 8'h01)
    else $error("ring count did not run freely");

  lock_hold_a: assert property (lockUntouched |=> lockFlag)
    else $error("lock dropped without a pll control write");
  lock_off_a: assert property (!pllEnableBit |=> !lockFlag && lockCount == 8'h00)
    else $error("lock kept while pll powered down");
  lock_event_a: assert property ($rose(lockFlag) |-> irqStatus[CSS_IRQ_LOCK_BIT])
    else $error("lock rise did not raise its status bit");
  stop_edge_a: assert property ($changed(stopGate) |-> !$past(curLevel))
    else $error("stop gate moved while the clock level was high");

endmodule
`default_nettype wire

//--- css_ext_osc.sv
`timescale 1ns/1ps
`default_nettype none
module css_ext_osc #(
  parameter int HALF = 20
) (
  input wire logic clock,
  output logic externalClockInput
);
  int count = 0;
  initial externalClockInput = 1'b0;
  // A free-running oscillator on the falling edge, so its phase never lines up with the block's sampling.
  always @(negedge clock) begin
    if (count == HALF - 1) begin
      count <= 0;
      externalClockInput <= ~externalClockInput;
    end else begin
      count <= count + 1;
    end
  end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import css_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  css_bus_req_t busReq = '0;
  logic clockStop = 0;
  logic [CSS_DW-1:0] readData;
  logic externalClockInput, pllPowerEnable, firstCoreLock, secondCoreLock, coreClock, irq;
  logic [1:0] activeSource;
  int failures = 0;
  int num_checks = 0;
  always #2 clock = ~clock;
  css_ext_osc #(.HALF(20)) css_ext_osc_inst (.clock(clock), .externalClockInput(externalClockInput));
  css_clock_select css_clock_select_inst (.clock(clock), .reset_n(reset_n), .busReq(busReq),
    .readData(readData), .externalClockInput(externalClockInput), .clockStop(clockStop),
    .pllPowerEnable(pllPowerEnable), .firstCoreLock(firstCoreLock), .secondCoreLock(secondCoreLock),
    .coreClock(coreClock), .activeSource(activeSource), .irq(irq));
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    busReq <= '{addr: a, wdata: v, write: 1'b1, read: 1'b0};
    @(posedge clock);
    busReq.write <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string n);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
    @(posedge clock);
    busReq.read <= 1'b0;
    #1 chk(n, e, readData);
  endtask
  task automatic settle;
    @(posedge clock);
    #1;
  endtask
  task automatic rises(input int n, input int lo, input int hi, input string nm);
    int r;
    logic p;
    r = 0;
    p = coreClock;
    repeat (n) begin
      settle();
      if (coreClock === 1'b1 && p === 1'b0) r++;
      p = coreClock;
    end
    num_checks++;
    if (r < lo || r > hi) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, r);
    end
  endtask
  task automatic waitSrc(input logic [1:0] s);
    int i;
    for (i = 0; i < 1000 && activeSource !== s; i++) settle();
    chk("activeSource", 16'(s), 16'(activeSource));
    if (i == 1000) results();
  endtask
  task automatic waitLock;
    int i;
    for (i = 0; i < 4000 && firstCoreLock !== 1'b1; i++) settle();
    chk("firstCoreLock", 16'h0001, 16'(firstCoreLock));
    if (i == 4000) results();
  endtask
  task automatic t_reset;
    repeat (4) @(posedge clock);
    chk("activeSource", 16'h0000, 16'(activeSource));
    reset_n <= 1'b1;
    rc(CSS_PLLC_OFF, CSS_PLLC_RESET, "pllControl");
    rc(CSS_POWERC_OFF, CSS_POWERC_RESET, "powerControl");
    rc(CSS_IRQ_MASK_OFF, 16'(CSS_IRQ_RESET), "irqMask");
    chk("pllPowerEnable", 16'h0000, 16'(pllPowerEnable));
  endtask
  task automatic t_misc;
    rises(400, 9, 11, "extRises");
    @(posedge clock);
    clockStop <= 1'b1;
    repeat (30) @(posedge clock);
    rises(200, 0, 0, "stoppedRises");
    @(posedge clock);
    clockStop <= 1'b0;
    wr(8'h20, 16'hffff);
    rc(8'h20, 16'h0000, "unmapped");
    rc(CSS_PLLC_OFF, 16'h0000, "pllControl");
  endtask
  task automatic t_pll;
    wr(CSS_IRQ_STAT_OFF, 16'h0003);
    wr(CSS_IRQ_MASK_OFF, 16'h0001);
    wr(CSS_PLLC_OFF, 16'h80e2);
    settle();
    chk("pllPowerEnable", 16'h0001, 16'(pllPowerEnable));
    chk("firstCoreLock", 16'h0000, 16'(firstCoreLock));
    waitLock();
    chk("secondCoreLock", 16'h0001, 16'(secondCoreLock));
    rc(CSS_STATUS_OFF, 16'h0001, "status");
    chk("irq", 16'h0001, 16'(irq));
    rc(CSS_IRQ_STAT_OFF, 16'h0001, "irqStatus");
    wr(CSS_IRQ_MASK_OFF, 16'h0000);
    settle();
    chk("irq", 16'h0000, 16'(irq));
    wr(CSS_IRQ_STAT_OFF, 16'h0001);
    rc(CSS_IRQ_STAT_OFF, 16'h0000, "irqStatus");
    wr(CSS_PLLC_OFF, 16'h80e2);
    rc(CSS_STATUS_OFF, 16'h0000, "status");
    waitLock();
    wr(CSS_IRQ_MASK_OFF, 16'h0002);
    wr(CSS_PLLC_OFF, 16'hc0e2);
    waitSrc(CSS_SRC_PLL);
    settle();
    chk("irq", 16'h0001, 16'(irq));
    rc(CSS_STATUS_OFF, 16'h0004, "status");
    rc(CSS_IRQ_STAT_OFF, 16'h0003, "irqStatus");
    wr(CSS_POWERC_OFF, 16'h0400);
    repeat (100) @(posedge clock);
    chk("activeSource", 16'(CSS_SRC_PLL), 16'(activeSource));
    rises(400, 19, 21, "pllRises");
    wr(CSS_PLLC_OFF, 16'h80e2);
    waitSrc(CSS_SRC_SLOW);
    rises(400, 3, 5, "ringRises");
    wr(CSS_IRQ_STAT_OFF, 16'h0003);
    settle();
    chk("irq", 16'h0000, 16'(irq));
    wr(CSS_POWERC_OFF, 16'h0000);
    waitSrc(CSS_SRC_EXT);
    wr(CSS_PLLC_OFF, 16'h0000);
    settle();
    chk("pllPowerEnable", 16'h0000, 16'(pllPowerEnable));
  endtask
  initial begin
    t_reset();
    t_misc();
    t_pll();
    results();
  end
endmodule
`default_nettype wire
